/* File: hw/tcs_pkg.sv */
// Constants, field layouts and bus carriers for the timer counter block.
// Assumes a 32-bit AXI4-Lite register bus and a single 50 MHz clock.

package tcs_pkg;

	// ==========================================================
	// Bus widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// ==========================================================
	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_COUNT_VALUE_LOW  = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_COUNT_VALUE_HIGH = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_COMPARE_A_VALUE  = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_COMPARE_B_VALUE  = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_TIMER_CONTROL_A  = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_TIMER_CONTROL_B  = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_TIMER_IRQ_FLAGS  = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_TIMER_IRQ_MASK   = 8'h1c;
	localparam logic [ADDR_W-1:0] OFS_TIMER_STATUS     = 8'h20;

	// ==========================================================
	// Field positions
	localparam int BIT_CLEAR_ON_MATCH = 0;
	localparam int BIT_WIDE_MODE      = 1;
	localparam int BIT_OVERFLOW       = 0;
	localparam int BIT_MATCH          = 1;
	localparam int BIT_AT_BOTTOM      = 0;
	localparam int BIT_AT_TOP         = 1;
	localparam int BIT_AT_MAX         = 2;
	localparam int NUM_FLAGS          = 2;

	// ==========================================================
	// Reset values and count limits
	localparam logic [7:0]  RST_BYTE     = 8'h00;
	localparam logic [15:0] RST_COUNT    = 16'h0000;
	localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
	localparam logic [15:0] COUNT_MAX8   = 16'h00ff;
	localparam logic [15:0] COUNT_MAX16  = 16'hffff;

	// ==========================================================
	// Tick source encodings
	localparam logic [2:0] SEL_STOP     = 3'h0;
	localparam logic [2:0] SEL_SYSCLK   = 3'h1;
	localparam logic [2:0] SEL_TAP0     = 3'h2;
	localparam logic [2:0] SEL_TAP1     = 3'h3;
	localparam logic [2:0] SEL_TAP2     = 3'h4;
	localparam logic [2:0] SEL_TAP3     = 3'h5;
	localparam logic [2:0] SEL_EXT_FALL = 3'h6;
	localparam logic [2:0] SEL_EXT_RISE = 3'h7;

	// ==========================================================
	// Prescaler taps, timing and bus response codes
	localparam int          PRESC_W   = 10;
	localparam logic [9:0]  TAP0_MASK = 10'h007;
	localparam logic [9:0]  TAP1_MASK = 10'h03f;
	localparam logic [9:0]  TAP2_MASK = 10'h0ff;
	localparam logic [9:0]  TAP3_MASK = 10'h3ff;
	localparam int          SYNC_STAGES = 2;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// ==========================================================
	// AXI4-Lite carriers
	typedef struct packed {
		logic [ADDR_W-1:0]   awaddr;
		logic                awvalid;
		logic [DATA_W-1:0]   wdata;
		logic [DATA_W/8-1:0] wstrb;
		logic                wvalid;
		logic                bready;
		logic [ADDR_W-1:0]   araddr;
		logic                arvalid;
		logic                rready;
	} tcs_axi_req_type;

	typedef struct packed {
		logic              awready;
		logic              wready;
		logic [1:0]        bresp;
		logic              bvalid;
		logic              arready;
		logic [DATA_W-1:0] rdata;
		logic [1:0]        rresp;
		logic              rvalid;
	} tcs_axi_rsp_type;

endpackage

/* File: hw/tcs_timer.sv */
// Timer counter with tick source selection, AXI4-Lite registers and overflow interrupt.
// Assumes one clock domain; the external count pin is asynchronous to it.

`timescale 1ns/1ns

// Contract
// - Wide mode adds counter high byte register
// - Wide mode joins compare A low, B high
// - Counter at zero means bottom
// - Counter at 255 (65535 when wide) means max
// - Top is max or compare A (B:A when wide) by mode
// - Tick source select field picks timer tick
// - Select one counts every system clock
// - Four prescaler taps offered as sources
// - Pin synchronised, edge detected, 2-3 cycles
// - Pin ticks bypass the prescaler
// - Increment per tick, wrap after top
// - Select zero stops the counter
// - Counter readable and writable any time
// - Software write beats clear and increment
// - Overflow flag set on a tick while at max
// - Flags visible, each request masked
module tcs_timer
	import tcs_pkg::*;
#(
	parameter int PRESC_WIDTH = PRESC_W
) (
	input  wire logic            CLOCK,
	input  wire logic            RSTN,
	input  wire tcs_axi_req_type S_AXI_REQ,
	output tcs_axi_rsp_type      S_AXI_RSP,
	input  wire logic            EXT_COUNT_PIN,
	input  wire logic            IRQ_ACK,
	output logic                 TIMER_IRQ
);

	// ==========================================================
	// Elaboration check
	if (PRESC_WIDTH < PRESC_W) begin : g_presc_check
		$error("PRESC_WIDTH too small for the widest prescaler tap");
	end

	// ==========================================================
	// Functions
	function automatic logic tap_hit(input logic [9:0] presc, input logic [9:0] mask);
		tap_hit = &(presc | ~mask);
	endfunction

	function automatic logic offset_is(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] ofs);
		offset_is = (addr == ofs);
	endfunction

	// ==========================================================
	// Register state
	logic [15:0]            count_value_q;
	logic [15:0]            count_value_d;
	logic [7:0]             count_value_high_q;
	logic [7:0]             count_value_high_d;
	logic [7:0]             compare_a_value_q;
	logic [7:0]             compare_b_value_q;
	logic [1:0]             timer_control_a_q;
	logic [2:0]             timer_control_b_q;
	logic [NUM_FLAGS-1:0]   timer_irq_flags_q;
	logic [NUM_FLAGS-1:0]   timer_irq_flags_d;
	logic [NUM_FLAGS-1:0]   timer_irq_mask_q;
	logic [PRESC_WIDTH-1:0] presc_q;
	logic                   ext_sync1_q;
	logic                   ext_sync2_q;
	logic                   ext_prev_q;

	// ==========================================================
	// Bus state
	logic [ADDR_W-1:0] aw_addr_q;
	logic              aw_full_q;
	logic [DATA_W-1:0] w_data_q;
	logic [3:0]        w_strb_q;
	logic              w_full_q;
	logic              bvalid_q;
	logic [1:0]        bresp_q;
	logic              rvalid_q;
	logic [1:0]        rresp_q;
	logic [DATA_W-1:0] rdata_q;

	// ==========================================================
	// Bus handshakes and decode
	wire aw_take   = S_AXI_REQ.awvalid & ~aw_full_q;
	wire w_take    = S_AXI_REQ.wvalid & ~w_full_q;
	wire wr_commit = aw_full_q & w_full_q & ~bvalid_q;
	wire ar_take   = S_AXI_REQ.arvalid & ~rvalid_q;
	wire wr_lane0  = wr_commit & w_strb_q[0];
	wire [7:0] wr_byte = w_data_q[7:0];

	wire wr_cnt_low  = wr_lane0 & offset_is(aw_addr_q, OFS_COUNT_VALUE_LOW);
	wire wr_cnt_high = wr_lane0 & offset_is(aw_addr_q, OFS_COUNT_VALUE_HIGH);
	wire wr_cmp_a    = wr_lane0 & offset_is(aw_addr_q, OFS_COMPARE_A_VALUE);
	wire wr_cmp_b    = wr_lane0 & offset_is(aw_addr_q, OFS_COMPARE_B_VALUE);
	wire wr_ctrl_a   = wr_lane0 & offset_is(aw_addr_q, OFS_TIMER_CONTROL_A);
	wire wr_ctrl_b   = wr_lane0 & offset_is(aw_addr_q, OFS_TIMER_CONTROL_B);
	wire wr_flags    = wr_lane0 & offset_is(aw_addr_q, OFS_TIMER_IRQ_FLAGS);
	wire wr_mask     = wr_lane0 & offset_is(aw_addr_q, OFS_TIMER_IRQ_MASK);
	wire wr_status   = offset_is(aw_addr_q, OFS_TIMER_STATUS);
	wire wr_mapped   = offset_is(aw_addr_q, OFS_COUNT_VALUE_LOW) | offset_is(aw_addr_q, OFS_COUNT_VALUE_HIGH)
		| offset_is(aw_addr_q, OFS_COMPARE_A_VALUE) | offset_is(aw_addr_q, OFS_COMPARE_B_VALUE)
		| offset_is(aw_addr_q, OFS_TIMER_CONTROL_A) | offset_is(aw_addr_q, OFS_TIMER_CONTROL_B)
		| offset_is(aw_addr_q, OFS_TIMER_IRQ_FLAGS) | offset_is(aw_addr_q, OFS_TIMER_IRQ_MASK)
		| wr_status;
	wire [1:0] wr_resp = wr_mapped ? RESP_OKAY : RESP_SLVERR;

	wire rd_cnt_low = ar_take & offset_is(S_AXI_REQ.araddr, OFS_COUNT_VALUE_LOW);

	// ==========================================================
	// Mode, limits and compare
	wire wide_mode      = timer_control_a_q[BIT_WIDE_MODE];
	wire clear_on_match = timer_control_a_q[BIT_CLEAR_ON_MATCH];
	wire [15:0] compare_word = wide_mode ? {compare_b_value_q, compare_a_value_q}
		: {8'h00, compare_a_value_q};
	wire [15:0] max_value = wide_mode ? COUNT_MAX16 : COUNT_MAX8;
	wire [15:0] top_value = clear_on_match ? compare_word : max_value;
	wire at_bottom = (count_value_q == COUNT_BOTTOM);
	wire at_max    = (count_value_q == max_value);
	wire at_top    = (count_value_q == top_value);

	// ==========================================================
	// Tick source selection
	wire ext_rise = ext_sync2_q & ~ext_prev_q;
	wire ext_fall = ~ext_sync2_q & ext_prev_q;
	wire [9:0] presc_low = presc_q[9:0];
	wire tap0 = tap_hit(presc_low, TAP0_MASK);
	wire tap1 = tap_hit(presc_low, TAP1_MASK);
	wire tap2 = tap_hit(presc_low, TAP2_MASK);
	wire tap3 = tap_hit(presc_low, TAP3_MASK);
	logic timer_tick;

	always_comb begin
		case (timer_control_b_q)
			SEL_STOP:     timer_tick = 1'b0;
			SEL_SYSCLK:   timer_tick = 1'b1;
			SEL_TAP0:     timer_tick = tap0;
			SEL_TAP1:     timer_tick = tap1;
			SEL_TAP2:     timer_tick = tap2;
			SEL_TAP3:     timer_tick = tap3;
			SEL_EXT_FALL: timer_tick = ext_fall;
			SEL_EXT_RISE: timer_tick = ext_rise;
			default:      timer_tick = 1'b0;
		endcase
	end

	// ==========================================================
	// Counter next value
	wire [15:0] count_inc  = count_value_q + 16'h0001;
	wire [15:0] count_step = at_top ? COUNT_BOTTOM : count_inc;
	wire [15:0] count_sw   = wide_mode ? {count_value_high_q, wr_byte} : {8'h00, wr_byte};

	always_comb begin
		if (wr_cnt_low) begin
			count_value_d = count_sw;
		end else if (timer_tick) begin
			count_value_d = count_step;
		end else begin
			count_value_d = count_value_q;
		end
	end

	// High byte temporary: staged by a write, loaded by a low byte read
	always_comb begin
		if (wr_cnt_high) begin
			count_value_high_d = wr_byte;
		end else if (rd_cnt_low) begin
			count_value_high_d = count_value_q[15:8];
		end else begin
			count_value_high_d = count_value_high_q;
		end
	end

	// ==========================================================
	// Interrupt flags
	wire [NUM_FLAGS-1:0] flag_set;
	wire [NUM_FLAGS-1:0] flag_clr;
	assign flag_set[BIT_OVERFLOW] = timer_tick & at_max & ~wr_cnt_low;
	assign flag_set[BIT_MATCH]    = timer_tick & at_top & clear_on_match & ~wr_cnt_low;
	assign flag_clr[BIT_OVERFLOW] = (wr_flags & wr_byte[BIT_OVERFLOW]) | IRQ_ACK;
	assign flag_clr[BIT_MATCH]    = wr_flags & wr_byte[BIT_MATCH];

	always_comb begin
		timer_irq_flags_d = flag_set | (timer_irq_flags_q & ~flag_clr);
	end

	// ==========================================================
	// Read data
	wire [7:0] status_byte = {5'h00, at_max, at_top, at_bottom};
	logic [DATA_W-1:0] rd_data;
	logic              rd_hit;

	always_comb begin
		rd_data = 32'h0000_0000;
		rd_hit  = 1'b1;
		case (S_AXI_REQ.araddr)
			OFS_COUNT_VALUE_LOW:  rd_data[7:0] = count_value_q[7:0];
			OFS_COUNT_VALUE_HIGH: rd_data[7:0] = count_value_high_q;
			OFS_COMPARE_A_VALUE:  rd_data[7:0] = compare_a_value_q;
			OFS_COMPARE_B_VALUE:  rd_data[7:0] = compare_b_value_q;
			OFS_TIMER_CONTROL_A:  rd_data[1:0] = timer_control_a_q;
			OFS_TIMER_CONTROL_B:  rd_data[2:0] = timer_control_b_q;
			OFS_TIMER_IRQ_FLAGS:  rd_data[1:0] = timer_irq_flags_q;
			OFS_TIMER_IRQ_MASK:   rd_data[1:0] = timer_irq_mask_q;
			OFS_TIMER_STATUS:     rd_data[7:0] = status_byte;
			default:              rd_hit = 1'b0;
		endcase
	end

	// ==========================================================
	// Outputs
	assign S_AXI_RSP.awready = ~aw_full_q;
	assign S_AXI_RSP.wready  = ~w_full_q;
	assign S_AXI_RSP.bvalid  = bvalid_q;
	assign S_AXI_RSP.bresp   = bresp_q;
	assign S_AXI_RSP.arready = ~rvalid_q;
	assign S_AXI_RSP.rvalid  = rvalid_q;
	assign S_AXI_RSP.rresp   = rresp_q;
	assign S_AXI_RSP.rdata   = rdata_q;
	assign TIMER_IRQ = |(timer_irq_flags_q & timer_irq_mask_q);

	// ==========================================================
	// Pin synchroniser and edge history
	always_ff @(posedge CLOCK) begin
		if (!RSTN) begin
			ext_sync1_q <= 1'b0;
			ext_sync2_q <= 1'b0;
			ext_prev_q  <= 1'b0;
		end else begin
			ext_sync1_q <= EXT_COUNT_PIN;
			ext_sync2_q <= ext_sync1_q;
			ext_prev_q  <= ext_sync2_q;
		end
	end

	// ==========================================================
	// Prescaler
	always_ff @(posedge CLOCK) begin
		if (!RSTN) begin
			presc_q <= '0;
		end else begin
			presc_q <= presc_q + {{(PRESC_WIDTH-1){1'b0}}, 1'b1};
		end
	end

	// ==========================================================
	// Timer registers
	always_ff @(posedge CLOCK) begin
		if (!RSTN) begin
			count_value_q      <= RST_COUNT;
			count_value_high_q <= RST_BYTE;
			timer_irq_flags_q  <= '0;
		end else begin
			count_value_q      <= count_value_d;
			count_value_high_q <= count_value_high_d;
			timer_irq_flags_q  <= timer_irq_flags_d;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RSTN) begin
			compare_a_value_q <= RST_BYTE;
			compare_b_value_q <= RST_BYTE;
			timer_control_a_q <= '0;
			timer_control_b_q <= SEL_STOP;
			timer_irq_mask_q  <= '0;
		end else begin
			if (wr_cmp_a) begin
				compare_a_value_q <= wr_byte;
			end
			if (wr_cmp_b) begin
				compare_b_value_q <= wr_byte;
			end
			if (wr_ctrl_a) begin
				timer_control_a_q <= wr_byte[1:0];
			end
			if (wr_ctrl_b) begin
				timer_control_b_q <= wr_byte[2:0];
			end
			if (wr_mask) begin
				timer_irq_mask_q <= wr_byte[NUM_FLAGS-1:0];
			end
		end
	end

	// ==========================================================
	// Write channel
	always_ff @(posedge CLOCK) begin
		if (!RSTN) begin
			aw_addr_q <= '0;
			aw_full_q <= 1'b0;
			w_data_q  <= '0;
			w_strb_q  <= '0;
			w_full_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_addr_q <= S_AXI_REQ.awaddr;
				aw_full_q <= 1'b1;
			end else if (wr_commit) begin
				aw_full_q <= 1'b0;
			end
			if (w_take) begin
				w_data_q <= S_AXI_REQ.wdata;
				w_strb_q <= S_AXI_REQ.wstrb;
				w_full_q <= 1'b1;
			end else if (wr_commit) begin
				w_full_q <= 1'b0;
			end
			if (wr_commit) begin
				bvalid_q <= 1'b1;
				bresp_q  <= wr_resp;
			end else if (S_AXI_REQ.bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Read channel
	always_ff @(posedge CLOCK) begin
		if (!RSTN) begin
			rvalid_q <= 1'b0;
			rresp_q  <= RESP_OKAY;
			rdata_q  <= '0;
		end else begin
			if (ar_take) begin
				rvalid_q <= 1'b1;
				rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
				rdata_q  <= rd_data;
			end else if (S_AXI_REQ.rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

endmodule

/* File: verification/tcs_cpu_model.sv */
// Processor core model: an AXI4-Lite master that reaches the timer registers.
// Assumes every task is entered just after a rising clock edge.

`timescale 1ns/1ns

module tcs_cpu_model
	import tcs_pkg::*;
(
	input  wire logic            clock,
	output tcs_axi_req_type      axi_req,
	input  wire tcs_axi_rsp_type axi_rsp
);
	// ==========================================================
	// Bus cycles, usable only once reset is released
	initial axi_req = '0;

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, output logic [1:0] r);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		axi_req.awaddr <= a;
		axi_req.awvalid <= 1'b1;
		axi_req.wdata <= d;
		axi_req.wstrb <= 4'hf;
		axi_req.wvalid <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge clock);
			if (!aw_ok && axi_rsp.awready) begin
				aw_ok = 1'b1;
				axi_req.awvalid <= 1'b0;
				axi_req.awaddr <= ~a;
			end
			if (!w_ok && axi_rsp.wready) begin
				w_ok = 1'b1;
				axi_req.wvalid <= 1'b0;
				axi_req.wdata <= ~d;
			end
		end
		while (!axi_rsp.bvalid) @(posedge clock);
		// Late ready: the slave must hold its answer for a cycle
		axi_req.bready <= 1'b1;
		do @(posedge clock); while (!axi_rsp.bvalid);
		r = axi_rsp.bresp;
		axi_req.bready <= 1'b0;
		@(posedge clock);
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic [1:0] r);
		axi_req.araddr <= a;
		axi_req.arvalid <= 1'b1;
		do @(posedge clock); while (!axi_rsp.arready);
		axi_req.arvalid <= 1'b0;
		axi_req.araddr <= ~a;
		do @(posedge clock); while (!axi_rsp.rvalid);
		// Late ready: the slave must hold its data for a cycle
		axi_req.rready <= 1'b1;
		do @(posedge clock); while (!axi_rsp.rvalid);
		d = axi_rsp.rdata;
		r = axi_rsp.rresp;
		axi_req.rready <= 1'b0;
		@(posedge clock);
	endtask
endmodule

/* File: verification/tcs_timer_properties.sv */
// Concurrent checks on the timer's register bus ports.
// Assumes it is bound into the timer top module.

`timescale 1ns/1ns

module tcs_timer_properties
	import tcs_pkg::*;
#(
	parameter int PRESC_WIDTH = PRESC_W
) (
	input wire logic            CLOCK,
	input wire logic            RSTN,
	input wire tcs_axi_req_type S_AXI_REQ,
	input wire tcs_axi_rsp_type S_AXI_RSP,
	input wire logic            EXT_COUNT_PIN,
	input wire logic            IRQ_ACK,
	input wire logic            TIMER_IRQ
);
	// ==========================================================
	// Handshake steps
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RSTN);

	sequence s_wr_take;
		S_AXI_REQ.awvalid && S_AXI_RSP.awready && S_AXI_REQ.wvalid && S_AXI_RSP.wready;
	endsequence
	sequence s_rd_take;
		S_AXI_REQ.arvalid && S_AXI_RSP.arready;
	endsequence

	// ==========================================================
	// Properties
	a_write_answer: assert property (s_wr_take |-> ##2 S_AXI_RSP.bvalid)
		else $error("write response late");
	a_write_busy: assert property (s_wr_take |=> !S_AXI_RSP.awready && !S_AXI_RSP.wready)
		else $error("write channel not held off");
	a_read_answer: assert property (s_rd_take |=> S_AXI_RSP.rvalid)
		else $error("read data late");
	a_read_holds: assert property (S_AXI_RSP.rvalid && !S_AXI_REQ.rready |=>
		S_AXI_RSP.rvalid && $stable(S_AXI_RSP.rdata) && $stable(S_AXI_RSP.rresp))
		else $error("read data dropped");
	a_bresp_holds: assert property (S_AXI_RSP.bvalid && !S_AXI_REQ.bready |=>
		S_AXI_RSP.bvalid && $stable(S_AXI_RSP.bresp))
		else $error("write response dropped");
	a_ar_blocked: assert property (S_AXI_RSP.rvalid |-> !S_AXI_RSP.arready)
		else $error("read address open while data pending");
	a_read_ends: assert property (S_AXI_RSP.rvalid && S_AXI_REQ.rready |=> !S_AXI_RSP.rvalid)
		else $error("read data repeated");
	a_bresp_ends: assert property (S_AXI_RSP.bvalid && S_AXI_REQ.bready |=> !S_AXI_RSP.bvalid)
		else $error("write response repeated");
	a_rvalid_cause: assert property ($rose(S_AXI_RSP.rvalid) |-> $past(S_AXI_REQ.arvalid && S_AXI_RSP.arready))
		else $error("read data without request");
endmodule

bind tcs_timer tcs_timer_properties #(.PRESC_WIDTH(PRESC_WIDTH)) i_props (.CLOCK(CLOCK), .RSTN(RSTN),
	.S_AXI_REQ(S_AXI_REQ), .S_AXI_RSP(S_AXI_RSP), .EXT_COUNT_PIN(EXT_COUNT_PIN), .IRQ_ACK(IRQ_ACK),
	.TIMER_IRQ(TIMER_IRQ));

/* File: verification/test_timer0_counter_clock_select.sv */
// Self-checking bench for the timer counter with tick source selection.
// Assumes the processor core model and the bound property checker.

`timescale 1ns/1ns

module test_timer0_counter_clock_select;
	import tcs_pkg::*;
	localparam logic [7:0] GO   = {5'h00, SEL_SYSCLK};
	localparam logic [7:0] STOP = {5'h00, SEL_STOP};
	logic            clock = 1'b0;
	logic            rstn;
	logic            ext_pin;
	logic            irq_ack;
	logic            timer_irq;
	tcs_axi_req_type axi_req;
	tcs_axi_rsp_type axi_rsp;
	int              cyc = 0;
	int              err_total = 0;
	int              samples_checked = 0;

	// ==========================================================
	// Clock and instances
	always #10 clock = ~clock;
	always @(posedge clock) cyc <= cyc + 1;

	tcs_timer #(.PRESC_WIDTH(PRESC_W)) i_dut (.CLOCK(clock), .RSTN(rstn), .S_AXI_REQ(axi_req),
		.S_AXI_RSP(axi_rsp), .EXT_COUNT_PIN(ext_pin), .IRQ_ACK(irq_ack), .TIMER_IRQ(timer_irq));
	tcs_cpu_model i_cpu (.clock(clock), .axi_req(axi_req), .axi_rsp(axi_rsp));

	// ==========================================================
	// Helpers
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %0t %s got %h expected %h", $time, m, got, exp);
		end
	endtask

	task automatic w(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		logic [1:0] r;
		i_cpu.wr(a, {24'h000000, d}, r);
		chk({6'h00, r}, {6'h00, RESP_OKAY}, "write response");
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
		logic [31:0] x;
		logic [1:0]  r;
		i_cpu.rd(a, x, r);
		chk({6'h00, r}, {6'h00, RESP_OKAY}, "read response");
		d = x[7:0];
	endtask

	task automatic test_done;
		$display("comparisons %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_regs;
		logic [7:0]  v;
		logic [31:0] x;
		logic [1:0]  r;
		rd(OFS_TIMER_STATUS, v);
		chk(v, 8'h01, "status at bottom");
		w(OFS_COUNT_VALUE_LOW, 8'hff);
		rd(OFS_TIMER_STATUS, v);
		chk(v, 8'h06, "status at top and max");
		w(OFS_COUNT_VALUE_LOW, 8'h5a);
		repeat (50) @(posedge clock);
		rd(OFS_COUNT_VALUE_LOW, v);
		chk(v, 8'h5a, "stopped counter");
		i_cpu.rd(8'h40, x, r);
		chk({6'h00, r}, {6'h00, RESP_SLVERR}, "unmapped response");
		chk(x[7:0], 8'h00, "unmapped data");
	endtask

	task automatic t_taps;
		int         dv [5] = '{1, 8, 64, 256, 1024};
		int         win [5] = '{16, 2, 2, 2, 2};
		int         c1;
		logic [7:0] a, b;
		for (int i = 0; i < 5; i++) begin
			w(OFS_TIMER_CONTROL_B, 8'(i + 1));
			c1 = cyc;
			rd(OFS_COUNT_VALUE_LOW, a);
			while (cyc < c1 + win[i] * dv[i]) @(posedge clock);
			rd(OFS_COUNT_VALUE_LOW, b);
			w(OFS_TIMER_CONTROL_B, STOP);
			chk(8'(b - a), 8'(win[i]), "ticks in window");
		end
	endtask

	task automatic t_pin;
		logic [7:0] a, b;
		for (int s = 6; s < 8; s++) begin
			w(OFS_TIMER_CONTROL_B, 8'(s)); // Pin held low while switching
			rd(OFS_COUNT_VALUE_LOW, a);
			repeat (5) begin
				ext_pin <= 1'b1;
				repeat (3) @(posedge clock); // Half periods of three clocks
				ext_pin <= 1'b0;
				repeat (3) @(posedge clock);
			end
			repeat (6) @(posedge clock);
			rd(OFS_COUNT_VALUE_LOW, b);
			w(OFS_TIMER_CONTROL_B, STOP);
			chk(8'(b - a), 8'h05, "pin edges counted");
		end
	endtask

	task automatic t_prio;
		logic [7:0] v;
		w(OFS_TIMER_CONTROL_B, GO);
		w(OFS_COUNT_VALUE_LOW, 8'h33);
		rd(OFS_COUNT_VALUE_LOW, v);
		w(OFS_TIMER_CONTROL_B, STOP);
		chk({7'h00, 8'(v - 8'h33) < 8'h10}, 8'h01, "write overrides count");
	endtask

	task automatic t_ctc;
		logic [7:0] v;
		w(OFS_COMPARE_A_VALUE, 8'h05);
		w(OFS_TIMER_CONTROL_A, 8'h01);
		w(OFS_COUNT_VALUE_LOW, 8'h00);
		w(OFS_TIMER_CONTROL_B, GO);
		repeat (4) begin
			rd(OFS_COUNT_VALUE_LOW, v);
			chk({7'h00, v > 8'h05}, 8'h00, "count above compare top");
		end
		w(OFS_TIMER_CONTROL_B, STOP);
		rd(OFS_TIMER_IRQ_FLAGS, v);
		chk(v, 8'h02, "match flag only");
		w(OFS_TIMER_IRQ_FLAGS, 8'h03);
		w(OFS_TIMER_CONTROL_A, 8'h00);
	endtask

	task automatic t_wide;
		logic [7:0] lo, hi;
		w(OFS_TIMER_CONTROL_A, 8'h02);
		w(OFS_COUNT_VALUE_HIGH, 8'h12); // High byte staged first
		w(OFS_COUNT_VALUE_LOW, 8'h34);
		rd(OFS_COUNT_VALUE_LOW, lo);
		rd(OFS_COUNT_VALUE_HIGH, hi);
		chk(lo, 8'h34, "wide low byte");
		chk(hi, 8'h12, "wide high byte");
		w(OFS_COMPARE_A_VALUE, 8'h05);
		w(OFS_COMPARE_B_VALUE, 8'h01);
		w(OFS_TIMER_CONTROL_A, 8'h03);
		w(OFS_COUNT_VALUE_HIGH, 8'h01);
		w(OFS_COUNT_VALUE_LOW, 8'h00);
		w(OFS_TIMER_CONTROL_B, GO);
		repeat (3) begin
			rd(OFS_COUNT_VALUE_LOW, lo);
			rd(OFS_COUNT_VALUE_HIGH, hi);
			chk({7'h00, {hi, lo} > 16'h0105}, 8'h00, "wide compare top");
		end
		w(OFS_TIMER_CONTROL_B, STOP);
		w(OFS_TIMER_CONTROL_A, 8'h00);
		w(OFS_TIMER_IRQ_FLAGS, 8'h03);
	endtask

	task automatic t_ovf;
		logic [7:0] v;
		w(OFS_TIMER_IRQ_MASK, 8'h01);
		for (int k = 0; k < 2; k++) begin
			w(OFS_COUNT_VALUE_LOW, 8'hfe);
			w(OFS_TIMER_CONTROL_B, GO);
			repeat (6) @(posedge clock);
			w(OFS_TIMER_CONTROL_B, STOP);
			repeat (20) @(posedge clock);
			rd(OFS_TIMER_IRQ_FLAGS, v);
			chk(v, 8'h01, "overflow flag kept");
			chk({7'h00, timer_irq}, 8'h01, "request raised");
			w(OFS_TIMER_IRQ_MASK, 8'h00);
			chk({7'h00, timer_irq}, 8'h00, "request masked");
			w(OFS_TIMER_IRQ_MASK, 8'h01);
			if (k == 0) begin
				irq_ack <= 1'b1;
				@(posedge clock);
				irq_ack <= 1'b0;
			end else
				w(OFS_TIMER_IRQ_FLAGS, 8'h01);
			repeat (2) @(posedge clock);
			chk({7'h00, timer_irq}, 8'h00, "request cleared");
		end
		w(OFS_TIMER_IRQ_MASK, 8'h00);
	endtask

	// ==========================================================
	// Main sequence and watchdog
	initial begin
		rstn = 1'b0;
		ext_pin = 1'b0;
		irq_ack = 1'b0;
		repeat (2) @(posedge clock);
		rstn <= 1'b1;
		@(posedge clock);
		t_regs;
		t_taps;
		t_pin;
		t_prio;
		t_ctc;
		t_wide;
		t_ovf;
		test_done;
	end

	initial begin
		repeat (20000) @(posedge clock);
		err_total++;
		test_done;
	end
endmodule
